// [ccr_router.sv]
// Functional notes
// [R1] software masks reserved bits, merges on writes
// [R2] address register may be written directly
// [R3] reserved locations untouched; may read nonzero
// [R4] reset loads defaults, some from straps
// [R5] internal functions sit on bus zero
// [R6] device 0 host, 2-4 wide bridges
// [R7] disabled interface: reads ones, writes abort
// [R8] mechanism one, eight functions, 256 bytes
// [R9] host sets address register by dword write
// [R10] enable bit clear means no config cycle
// [R11] data window access becomes a config cycle
// [R12] bus number bits 23:16 decoded with device
// [R13] enabled internal targets never reach legacy link
// [R14] bus 0 devices 8-31 go type 0
// [R15] unmatched nonzero bus: type 1 on legacy
// [R16] inside secondary-subordinate range: type 1 there
// [R17] gaps between ranges go to legacy link
// [R18] address layout fixed; reserved bits read zero
// [R19] partial address access passes as io cycle
// [R20] bus equal secondary: type 0 on link
// [R21] unimplemented bus 0 devices: ones, drop writes
`include "ccr_cfg.svh"
module ccr_router #(
    parameter int          N_WIDE      = 3,
    parameter logic [31:0] DEV_ID_WORD = 32'h5a5a_0001 // arbitrary value
) (
    // clock and reset
    input  wire logic                                clk_i,
    input  wire logic                                rst_i,
    // straps
    input  wire logic [N_WIDE-1:0]                   strap_en_i,
    // wishbone slave
    input  wire logic                                wb_cyc_i,
    input  wire logic                                wb_stb_i,
    input  wire logic                                wb_we_i,
    input  wire logic [15:0]                         wb_adr_i,
    input  wire logic [3:0]                          wb_sel_i,
    input  wire logic [31:0]                         wb_dat_i,
    output logic      [31:0]                         wb_dat_o,
    output logic                                     wb_ack_o,
    output logic                                     wb_err_o,
    // hub links, index 0 legacy
    output ccr_pkg::ccr_link_req_t [N_WIDE:0]        link_req_o,
    input  wire logic [N_WIDE:0]                     link_ack_i,
    input  wire logic [N_WIDE:0]                     link_abort_i,
    input  wire logic [31:0]                         link_rdata_i
);
    localparam int LS_W = 2;

    if (N_WIDE < 1 || N_WIDE > 3) begin : g_bad_width
        $error("N_WIDE must be 1 to 3");
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    ccr_pkg::ccr_state_t               st_q;
    ccr_pkg::ccr_route_t               route_c;
    ccr_pkg::ccr_kind_t                kind_c;
    ccr_pkg::ccr_link_req_t [N_WIDE:0] link_req_q;
    logic [31:0]                       cfg_addr_q;
    logic [15:0]                       scratch_q;
    logic [N_WIDE-1:0]                 strap_s1_q;
    logic [N_WIDE-1:0]                 strap_s2_q;
    logic [N_WIDE-1:0]                 strap_s3_q;
    logic [N_WIDE-1:0]                 link_en_q;
    logic                              strap_lock_q;
    logic [LS_W-1:0]                   lsel_c;
    logic [LS_W-1:0]                   lsel_q;
    logic [31:0]                       dat_q;
    logic                              ack_q;
    logic                              err_q;
    logic                              take_c;
    logic                              is_addr_c;
    logic                              is_data_c;
    logic                              config_cycle_enable_bit_w;
    logic [7:0]                        bus_w;
    logic [4:0]                        dev_w;
    logic [2:0]                        fn_w;
    logic [5:0]                        reg_w;
    logic [4:0]                        wdev_w;
    logic                              wide_dev_w;
    logic [N_WIDE-1:0]                 hit0_w;
    logic [N_WIDE-1:0]                 hit1_w;
    logic [N_WIDE-1:0]                 br_wr_w;
    logic [23:0]                       busnum_w [N_WIDE];
    logic [31:0]                       local_rd_c;

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    assign take_c     = (st_q == ccr_pkg::CCR_ST_IDLE) && wb_cyc_i && wb_stb_i;
    assign is_addr_c  = (wb_adr_i[15:2] == `CCR_IDX_ADDR);
    assign is_data_c  = (wb_adr_i[15:2] == `CCR_IDX_DATA);
    assign config_cycle_enable_bit_w     = cfg_addr_q[`CCR_EN_BIT];
    assign bus_w      = cfg_addr_q[`CCR_BUS_MSB:`CCR_BUS_LSB]; // R12
    assign dev_w      = cfg_addr_q[`CCR_DEV_MSB:`CCR_DEV_LSB];
    assign fn_w       = cfg_addr_q[`CCR_FN_MSB:`CCR_FN_LSB]; // R8
    assign reg_w      = cfg_addr_q[`CCR_REG_MSB:`CCR_REG_LSB];
    assign wdev_w     = dev_w - `CCR_DEV_WIDE0;
    assign wide_dev_w = (dev_w >= `CCR_DEV_WIDE0) && (wdev_w < 5'(N_WIDE)); // R6

    // ------------------------------------------------------------
    // strap capture, three stage synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        strap_s1_q <= strap_en_i;
        strap_s2_q <= strap_s1_q;
        strap_s3_q <= strap_s2_q;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strap_lock_q <= 1'b0;
        end else if (strap_s2_q == strap_s3_q) begin
            strap_lock_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!strap_lock_q && (strap_s2_q == strap_s3_q)) begin
            link_en_q <= strap_s3_q; // R4
        end
    end

    // ------------------------------------------------------------
    // wide link bridges
    // ------------------------------------------------------------
    for (genvar i = 0; i < N_WIDE; i++) begin : g_br
        assign br_wr_w[i] = take_c && wb_we_i && is_data_c && (route_c == ccr_pkg::CCR_RT_LOCAL)
                            && wide_dev_w && (wdev_w[LS_W-1:0] == LS_W'(i))
                            && (fn_w == `CCR_FN_CTRL) && (reg_w == `CCR_REG_BUSNUM);
        ccr_bridge u_br (
            .clk_i    (clk_i),
            .rst_i    (rst_i),
            .en_i     (link_en_q[i]),
            .wr_i     (br_wr_w[i]),
            .be_i     (wb_sel_i),
            .wdata_i  (wb_dat_i),
            .bus_i    (bus_w),
            .busnum_o (busnum_w[i]),
            .hit0_o   (hit0_w[i]),
            .hit1_o   (hit1_w[i])
        );
    end

    // ------------------------------------------------------------
    // routing decision
    // ------------------------------------------------------------
    always_comb begin
        route_c = ccr_pkg::CCR_RT_LOCAL;
        kind_c  = ccr_pkg::CCR_KIND_IO;
        lsel_c  = '0;
        if (is_addr_c) begin
            if (wb_sel_i != `CCR_SEL_DWORD) begin
                route_c = ccr_pkg::CCR_RT_LINK; // R19
            end
        end else if (is_data_c) begin
            if (!config_cycle_enable_bit_w) begin
                route_c = ccr_pkg::CCR_RT_LINK; // R10
            end else if (bus_w == `CCR_BUS_ZERO) begin // R5
                if (dev_w == `CCR_DEV_HOST) begin
                    route_c = (fn_w <= `CCR_FN_MAX) ? ccr_pkg::CCR_RT_LOCAL : ccr_pkg::CCR_RT_ONES; // R13
                end else if (wide_dev_w) begin
                    if (!link_en_q[wdev_w[LS_W-1:0]]) begin
                        route_c = ccr_pkg::CCR_RT_ABORT; // R7
                    end else if (fn_w <= `CCR_FN_MAX) begin
                        route_c = ccr_pkg::CCR_RT_LOCAL; // R13
                    end else begin
                        route_c = ccr_pkg::CCR_RT_ONES; // R21
                    end
                end else if (dev_w >= `CCR_DEV_FWD_LO) begin
                    route_c = ccr_pkg::CCR_RT_LINK; // R14
                    kind_c  = ccr_pkg::CCR_KIND_CFG0;
                end else begin
                    route_c = ccr_pkg::CCR_RT_ONES; // R21
                end
            end else begin
                route_c = ccr_pkg::CCR_RT_LINK; // R15 R17
                kind_c  = ccr_pkg::CCR_KIND_CFG1;
                for (int i = N_WIDE - 1; i >= 0; i--) begin
                    if (hit0_w[i]) begin
                        kind_c = ccr_pkg::CCR_KIND_CFG0; // R20
                        lsel_c = LS_W'(i + 1);
                    end else if (hit1_w[i]) begin
                        kind_c = ccr_pkg::CCR_KIND_CFG1; // R16
                        lsel_c = LS_W'(i + 1);
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // internal register read
    // ------------------------------------------------------------
    always_comb begin
        local_rd_c = `CCR_ZERO32; // R3
        if (is_data_c && fn_w == `CCR_FN_CTRL) begin
            if (reg_w == `CCR_REG_ID && (dev_w == `CCR_DEV_HOST || wide_dev_w)) begin
                local_rd_c = DEV_ID_WORD;
            end else if (dev_w == `CCR_DEV_HOST && reg_w == `CCR_REG_SCRATCH) begin
                local_rd_c = {scratch_q, `CCR_ZERO16};
            end else if (wide_dev_w && reg_w == `CCR_REG_BUSNUM) begin
                local_rd_c = {8'h00, busnum_w[wdev_w[LS_W-1:0]]};
            end
        end
    end

    // ------------------------------------------------------------
    // config address register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_addr_q <= `CCR_ADDR_RST; // R4
        end else if (take_c && wb_we_i && is_addr_c && wb_sel_i == `CCR_SEL_DWORD) begin
            cfg_addr_q <= wb_dat_i & `CCR_ADDR_WMASK; // R18
        end
    end

    // ------------------------------------------------------------
    // host scratch register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scratch_q <= `CCR_SCRATCH_RST; // R4
        end else if (take_c && wb_we_i && is_data_c && route_c == ccr_pkg::CCR_RT_LOCAL
                     && dev_w == `CCR_DEV_HOST && fn_w == `CCR_FN_CTRL && reg_w == `CCR_REG_SCRATCH) begin
            for (int b = 2; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    scratch_q[8*(b-2) +: 8] <= wb_dat_i[8*b +: 8];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // link requests, held until the link acknowledges
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        for (int i = 0; i <= N_WIDE; i++) begin
            if (rst_i) begin
                link_req_q[i] <= '0;
            end else if (take_c && route_c == ccr_pkg::CCR_RT_LINK && lsel_c == LS_W'(i)) begin
                link_req_q[i].valid <= 1'b1; // R11
                link_req_q[i].kind  <= kind_c;
                link_req_q[i].we    <= wb_we_i;
                link_req_q[i].addr  <= (kind_c == ccr_pkg::CCR_KIND_IO) ? {16'h0000, wb_adr_i} : cfg_addr_q;
                link_req_q[i].be    <= wb_sel_i;
                link_req_q[i].wdata <= wb_dat_i;
            end else if (st_q == ccr_pkg::CCR_ST_LINK && lsel_q == LS_W'(i) && link_ack_i[i]) begin
                link_req_q[i].valid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // bus answer state machine
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q   <= ccr_pkg::CCR_ST_IDLE;
            ack_q  <= 1'b0;
            err_q  <= 1'b0;
            dat_q  <= `CCR_ZERO32;
            lsel_q <= '0;
        end else begin
            case (st_q)
                ccr_pkg::CCR_ST_IDLE: begin
                    if (take_c && route_c == ccr_pkg::CCR_RT_LINK) begin
                        lsel_q <= lsel_c;
                        st_q   <= ccr_pkg::CCR_ST_LINK;
                    end else if (take_c) begin
                        ack_q <= !(route_c == ccr_pkg::CCR_RT_ABORT && wb_we_i);
                        err_q <= (route_c == ccr_pkg::CCR_RT_ABORT) && wb_we_i; // R7
                        if (route_c == ccr_pkg::CCR_RT_ONES || route_c == ccr_pkg::CCR_RT_ABORT) begin
                            dat_q <= `CCR_ONES; // R7 R21
                        end else if (is_addr_c) begin
                            dat_q <= cfg_addr_q;
                        end else begin
                            dat_q <= local_rd_c;
                        end
                        st_q <= ccr_pkg::CCR_ST_ANS;
                    end
                end
                ccr_pkg::CCR_ST_LINK: begin
                    if (link_ack_i[lsel_q]) begin
                        ack_q <= !(link_abort_i[lsel_q] && wb_we_i);
                        err_q <= link_abort_i[lsel_q] && wb_we_i;
                        dat_q <= link_abort_i[lsel_q] ? `CCR_ONES : link_rdata_i;
                        st_q  <= ccr_pkg::CCR_ST_ANS;
                    end
                end
                ccr_pkg::CCR_ST_ANS: begin
                    ack_q <= 1'b0;
                    err_q <= 1'b0;
                    st_q  <= ccr_pkg::CCR_ST_IDLE;
                end
                default: begin
                    st_q <= ccr_pkg::CCR_ST_IDLE;
                end
            endcase
        end
    end

    assign wb_dat_o   = dat_q;
    assign wb_ack_o   = ack_q;
    assign wb_err_o   = err_q;
    assign link_req_o = link_req_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_take_local;
        take_c && route_c != ccr_pkg::CCR_RT_LINK;
    endsequence

    sequence s_take_disabled;
        take_c && is_data_c && config_cycle_enable_bit_w && bus_w == `CCR_BUS_ZERO && wide_dev_w
        && !link_en_q[wdev_w[LS_W-1:0]];
    endsequence

    sequence s_take_nonzero_bus;
        take_c && is_data_c && config_cycle_enable_bit_w && bus_w != `CCR_BUS_ZERO;
    endsequence

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o && !wb_err_o) // R11
        else $error("ack held longer than one cycle");
    local_answer_a: assert property (s_take_local |=> (wb_ack_o ^ wb_err_o)) // R13
        else $error("local access not answered next cycle");
    dis_wr_abort_a: assert property (s_take_disabled ##0 wb_we_i |=> wb_err_o && !wb_ack_o) // R7
        else $error("write to disabled interface not aborted");
    dis_rd_ones_a: assert property (s_take_disabled ##0 !wb_we_i |=> wb_ack_o && wb_dat_o == `CCR_ONES) // R7
        else $error("read of disabled interface not all ones");
    addr_rsvd_a: assert property (cfg_addr_q[`CCR_RSV_HI_MSB:`CCR_RSV_HI_LSB] == '0
                                  && cfg_addr_q[1:0] == 2'b00) // R18
        else $error("reserved address bits not zero");
    no_cfg_off_a: assert property ($rose(link_req_q[0].valid) && link_req_q[0].kind != ccr_pkg::CCR_KIND_IO
                                   |-> config_cycle_enable_bit_w) // R10
        else $error("config cycle issued while disabled");
    fwd_dev_a: assert property ($rose(link_req_q[0].valid) && link_req_q[0].kind == ccr_pkg::CCR_KIND_CFG0
                                |-> dev_w >= `CCR_DEV_FWD_LO && bus_w == `CCR_BUS_ZERO) // R13 R14
        else $error("type 0 forward to internal device");
    part_addr_a: assert property (take_c && is_addr_c && wb_sel_i != `CCR_SEL_DWORD
                                  |=> link_req_q[0].valid && link_req_q[0].kind == ccr_pkg::CCR_KIND_IO
                                  && $stable(cfg_addr_q)) // R19
        else $error("partial address access not passed through");
    gap_legacy_a: assert property (s_take_nonzero_bus ##0 (hit0_w == '0 && hit1_w == '0)
                                   |=> link_req_q[0].valid && link_req_q[0].kind == ccr_pkg::CCR_KIND_CFG1) // R15 R17
        else $error("unclaimed bus not sent type 1 on legacy");
    range_hit_a: assert property (s_take_nonzero_bus ##0 hit1_w[0]
                                  |=> link_req_q[1].valid && link_req_q[1].kind == ccr_pkg::CCR_KIND_CFG1) // R16
        else $error("bus in range not sent type 1 on link");
    sec_hit_a: assert property (s_take_nonzero_bus ##0 hit0_w[0]
                                |=> link_req_q[1].valid && link_req_q[1].kind == ccr_pkg::CCR_KIND_CFG0) // R20
        else $error("secondary bus not sent type 0 on link");
endmodule : ccr_router

// [ccr_cfg.svh]
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH
// ----------------------------------------------------------------
// io port word indices (byte address 0cf8 and 0cfc)
// ----------------------------------------------------------------
`define CCR_IDX_ADDR     14'h033e
`define CCR_IDX_DATA     14'h033f
`define CCR_SEL_DWORD    4'hf
`define CCR_ADDR_RST     32'h0000_0000
`define CCR_ADDR_WMASK   32'h80ff_fffc
`define CCR_ONES         32'hffff_ffff
`define CCR_ZERO32       32'h0000_0000
`define CCR_ZERO16       16'h0000
// ----------------------------------------------------------------
// config address fields
// ----------------------------------------------------------------
`define CCR_EN_BIT       31
`define CCR_BUS_MSB      23
`define CCR_BUS_LSB      16
`define CCR_DEV_MSB      15
`define CCR_DEV_LSB      11
`define CCR_FN_MSB       10
`define CCR_FN_LSB       8
`define CCR_REG_MSB      7
`define CCR_REG_LSB      2
`define CCR_RSV_HI_MSB   30
`define CCR_RSV_HI_LSB   24
`define CCR_BUS_ZERO     8'h00
`define CCR_DEV_HOST     5'h00
`define CCR_DEV_WIDE0    5'h02
`define CCR_DEV_FWD_LO   5'h08
`define CCR_FN_CTRL      3'h0
`define CCR_FN_MAX       3'h1
// ----------------------------------------------------------------
// internal register locations and defaults
// ----------------------------------------------------------------
`define CCR_REG_ID       6'h00
`define CCR_REG_BUSNUM   6'h06
`define CCR_REG_SCRATCH  6'h37
`define CCR_BUSNUM_RST   24'h00_0000
`define CCR_SCRATCH_RST  16'h0000
`define CCR_SEC_MSB      15
`define CCR_SEC_LSB      8
`define CCR_SUB_MSB      23
`define CCR_SUB_LSB      16
`endif

// [ccr_pkg.sv]
package ccr_pkg;
    // ------------------------------------------------------------
    // link cycle kinds, fsm states, routes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CCR_KIND_IO   = 2'b00,
        CCR_KIND_CFG0 = 2'b01,
        CCR_KIND_CFG1 = 2'b11
    } ccr_kind_t;

    typedef enum logic [1:0] {
        CCR_ST_IDLE = 2'b00,
        CCR_ST_LINK = 2'b01,
        CCR_ST_ANS  = 2'b11
    } ccr_state_t;

    typedef enum logic [1:0] {
        CCR_RT_LOCAL = 2'b00,
        CCR_RT_ONES  = 2'b01,
        CCR_RT_ABORT = 2'b11,
        CCR_RT_LINK  = 2'b10
    } ccr_route_t;

    typedef struct packed {
        logic        valid;
        ccr_kind_t   kind;
        logic        we;
        logic [31:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } ccr_link_req_t;
endpackage : ccr_pkg

// [ccr_bridge.sv]
`include "ccr_cfg.svh"
module ccr_bridge (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // control
    input  wire logic        en_i,
    input  wire logic        wr_i,
    input  wire logic [3:0]  be_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic [7:0]  bus_i,
    // status
    output logic      [23:0] busnum_o,
    output logic             hit0_o,
    output logic             hit1_o
);
    logic [23:0] busnum_q;
    logic [7:0]  sec_w;
    logic [7:0]  sub_w;

    // ------------------------------------------------------------
    // primary / secondary / subordinate bus numbers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busnum_q <= `CCR_BUSNUM_RST; // R4
        end else if (wr_i) begin
            for (int b = 0; b < 3; b++) begin
                if (be_i[b]) begin
                    busnum_q[8*b +: 8] <= wdata_i[8*b +: 8];
                end
            end
        end
    end

    assign busnum_o = busnum_q;
    assign sec_w    = busnum_q[`CCR_SEC_MSB:`CCR_SEC_LSB];
    assign sub_w    = busnum_q[`CCR_SUB_MSB:`CCR_SUB_LSB];
    assign hit0_o   = en_i && (bus_i != `CCR_BUS_ZERO) && (bus_i == sec_w); // R20
    assign hit1_o   = en_i && (bus_i != `CCR_BUS_ZERO) && (bus_i > sec_w) && (bus_i <= sub_w); // R16

    sec_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // R16
                                  wr_i && be_i[1] |=> sec_w == $past(wdata_i[`CCR_SEC_MSB:`CCR_SEC_LSB]))
        else $error("secondary bus number write lost");
endmodule : ccr_bridge

// [ccr_link_model.sv]
module ccr_link_model (
    // clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    // requests from the router, answer control
    input  wire ccr_pkg::ccr_link_req_t [3:0] req_i,
    input  wire logic                         abort_cmd_i,
    input  wire logic [3:0]                   wait_i,
    // answers
    output logic      [3:0]                   ack_o,
    output logic      [3:0]                   abort_o,
    output logic      [31:0]                  rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q;
    always_ff @(posedge clk_i) begin
        ack_o   <= 4'h0;
        abort_o <= 4'h0;
        // released data never holds its last value
        rdata_o <= ~rdata_o;
        if (rst_i) begin
            cnt_q   <= 4'h0;
            rdata_o <= 32'h0000_0000;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (req_i[i].valid && ack_o == 4'h0) begin
                    if (cnt_q == wait_i) begin
                        ack_o[i]   <= 1'b1;
                        abort_o[i] <= abort_cmd_i;
                        rdata_o    <= ~req_i[i].addr;
                        cnt_q      <= 4'h0;
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
            end
        end
    end
endmodule : ccr_link_model

// [ccr_router_tb.sv]
module ccr_router_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, abt = 0, er, ack, err;
    logic [2:0] strap = 3'h3;
    logic [3:0] sel = 0, wt = 0, lack, labt;
    logic [15:0] adr = 0;
    logic [31:0] wd = 0, rd, lrd, dat, hit, kd, la, cur, lw, lb;
    logic [7:0] b;
    logic [7:0] corner [6] = '{8'h02, 8'h05, 8'h06, 8'h08, 8'h0c, 8'h0d};
    ccr_pkg::ccr_link_req_t [3:0] req;
    int bad_count = 0, check_count = 0, seed = 94;
    always #10 clk_i = ~clk_i;
    ccr_router i_dut (.clk_i(clk_i), .rst_i(rst_i), .strap_en_i(strap), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dat), .wb_ack_o(ack),
        .wb_err_o(err), .link_req_o(req), .link_ack_i(lack), .link_abort_i(labt), .link_rdata_i(lrd));
    ccr_link_model i_link (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .abort_cmd_i(abt), .wait_i(wt),
        .ack_o(lack), .abort_o(labt), .rdata_o(lrd));
    always @(posedge clk_i)
        for (int i = 0; i < 4; i++)
            if (req[i].valid === 1'b1) begin
                hit = i;
                kd = req[i].kind;
                la = req[i].addr;
                lw = req[i].wdata;
                lb = 32'({req[i].we, req[i].be});
            end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [15:0] a, input logic [3:0] s, input logic [31:0] d);
        hit = 32'hffff_ffff;
        @(posedge clk_i);
        cyc <= 1;
        we <= w;
        adr <= a;
        sel <= s;
        wd <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1 && err !== 1'b1);
        rd = dat;
        er = err;
        cyc <= 0;
    endtask : acc
    task automatic ca(input logic [7:0] bb, input logic [4:0] d, input logic [2:0] f, input logic [5:0] r);
        cur = {1'b1, 7'h00, bb, d, f, r, 2'b00};
        acc(1, 16'h0cf8, 4'hf, cur);
    endtask : ca
    task automatic lnk(input logic [31:0] e, input logic [31:0] a);
        chk("route", e, hit * 4 + kd);
        chk("cyc_addr", a, la);
    endtask : lnk
    // expected link index times four plus cycle kind
    function automatic logic [31:0] route(input logic [7:0] bb);
        if (bb == 8'h00) return 32'h0000_0001;
        if (bb == 8'h02) return 32'h0000_0005;
        if (bb > 8'h02 && bb <= 8'h05) return 32'h0000_0007;
        if (bb == 8'h08) return 32'h0000_0009;
        if (bb > 8'h08 && bb <= 8'h0c) return 32'h0000_000b;
        return 32'h0000_0003;
    endfunction : route
    initial begin
        #200_000;
        bad_count++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        acc(0, 16'h0cf8, 4'hf, 0);
        chk("addr_rst", 32'h0000_0000, rd);
        acc(1, 16'h0cf8, 4'hf, 32'hffff_ffff);
        acc(0, 16'h0cf8, 4'hf, 0);
        chk("addr_mask", 32'h80ff_fffc, rd);
        acc(1, 16'h0cf8, 4'h1, 32'h0000_0012);
        lnk(32'h0000_0000, 32'h0000_0cf8);
        chk("io_wdata", 32'h0000_0012, lw);
        chk("io_lanes", 32'h0000_0011, lb);
        acc(0, 16'h0cf8, 4'hf, 0);
        chk("addr_kept", 32'h80ff_fffc, rd);
        acc(1, 16'h0cf8, 4'hf, 0);
        acc(0, 16'h0cfc, 4'hf, 0);
        lnk(32'h0000_0000, 32'h0000_0cfc);
        for (int d = 0; d < 5; d++) begin
            ca(0, d, 0, 0);
            acc(0, 16'h0cfc, 4'hf, 0);
            chk("id", (d == 1 || d == 4) ? 32'hffff_ffff : 32'h5a5a_0001, rd);
            chk("local", 32'hffff_ffff, hit);
        end
        ca(0, 1, 0, 0);
        acc(1, 16'h0cfc, 4'hf, 32'h1234_5678);
        chk("drop", 32'h0000_0000, {31'h0, er});
        for (int d = 2; d < 5; d++) begin
            ca(0, d, 0, 6);
            acc(0, 16'h0cfc, 4'hf, 0);
            chk("bus_rst", d == 4 ? 32'hffff_ffff : 32'h0000_0000, rd);
            acc(1, 16'h0cfc, 4'hf, (rd & 32'hff00_0000) | (d == 2 ? 32'h0005_0200 : 32'h000c_0800));
            chk("wr_err", 32'(d == 4), {31'h0, er});
        end
        ca(0, 0, 2, 0);
        acc(0, 16'h0cfc, 4'hf, 0);
        chk("fn2", 32'hffff_ffff, rd);
        ca(0, 0, 0, 5);
        acc(0, 16'h0cfc, 4'hf, 0);
        chk("rsvd", 32'h0000_0000, rd);
        for (int n = 0; n < 40; n++) begin
            b = n < 6 ? corner[n] : 8'($unsigned($random(seed)) % 18);
            wt <= 4'($random(seed));
            ca(b, 5'(8 + $unsigned($random(seed)) % 24), 3'($random(seed)), 6'($random(seed)));
            acc(0, 16'h0cfc, 4'hf, 0);
            lnk(route(b), cur);
            chk("rdata", ~cur, rd);
        end
        abt <= 1;
        ca(7, 9, 0, 1);
        acc(0, 16'h0cfc, 4'hf, 0);
        chk("abt_rd", 32'hffff_ffff, rd);
        acc(1, 16'h0cfc, 4'hf, 32'h0000_0001);
        chk("abt_wr", 32'h0000_0001, {31'h0, er});
        give_verdict();
    end
endmodule : ccr_router_tb
